/* File: hdl/ccwe_exec.v */
// Execute unit for long call, clear register, complement register and clear watchdog.
`timescale 1ns/1ps

//
// How it works
// (RULE_01) Long call is two words, prefix 1111
// (RULE_02) Call pushes PC plus four as top
// (RULE_03) Save bit one copies W, status, bank
// (RULE_04) Save bit zero leaves shadows untouched
// (RULE_05) Twenty-bit literal loads PC bits 20:1
// (RULE_06) Call takes two cycles, second idle
// (RULE_07) Clear register writes zero, sets Z
// (RULE_08) Access bit picks access or selected bank
// (RULE_09) Extended set indexes addresses 5Fh and below
// (RULE_10) Clear watchdog zeroes counter, sets both flags
// (RULE_11) Clear watchdog also zeroes the postscaler
// (RULE_12) Complement register to W or file, N Z
// (RULE_13) Clear ops one cycle, read Q2 write Q4
module ccwe_exec
(
  // Clock and reset
  input  wire        clock_in,
  input  wire        rst_in,
  // AHB-Lite register bus
  input  wire        hsel_in,
  input  wire [31:0] haddr_in,
  input  wire [1:0]  htrans_in,
  input  wire        hwrite_in,
  input  wire [2:0]  hsize_in,
  input  wire        hready_in,
  input  wire [31:0] hwdata_in,
  output wire [31:0] hrdata_out,
  output wire        hreadyout_out,
  output wire        hresp_out,
  // Program memory fetch
  output reg  [20:0] fetch_addr_out,
  input  wire [15:0] instr_in,
  // Data memory
  input  wire [11:0] index_base_in,
  output reg  [11:0] dmem_addr_out,
  output reg         dmem_rd_out,
  input  wire [7:0]  dmem_rdata_in,
  output reg         dmem_wr_out,
  output reg  [7:0]  dmem_wdata_out,
  // Return stack
  output reg         stack_push_out,
  output reg  [20:0] top_of_stack_out,
  // Watchdog flags and phase state
  output reg         time_out_flag_out,
  output reg         power_down_flag_out,
  output wire [3:0]  phase_out
);
`include "ccwe_defs.vh"

  // ----------------------------------------------------------------------
  // Phase states, one-hot
  // ----------------------------------------------------------------------
  localparam [3:0] PH_Q1 = 4'b0001;
  localparam [3:0] PH_Q2 = 4'b0010;
  localparam [3:0] PH_Q3 = 4'b0100;
  localparam [3:0] PH_Q4 = 4'b1000;

  // Opcode classes of the latched instruction word.
  function [1:0] ccwe_class;
    input [15:0] word;
    begin
      if (word[15:9] == `CCWE_OP_CALL)
        ccwe_class = 2'd1;
      else if (word[15:9] == `CCWE_OP_CLRREG)
        ccwe_class = 2'd2;
      else if (word[15:10] == `CCWE_OP_COMREG)
        ccwe_class = 2'd3;
      else
        ccwe_class = 2'd0;
    end
  endfunction

  reg  [3:0]  phase_r;
  reg  [3:0]  phase_nxt;
  reg  [1:0]  ctrl_r;
  reg  [20:0] pc_r;
  reg  [15:0] ir_r;
  reg         idle_cycle_r;
  reg  [7:0]  w_r;
  reg  [4:0]  status_r;
  reg  [3:0]  bank_r;
  reg  [7:0]  working_shadow_r;
  reg  [4:0]  status_shadow_r;
  reg  [3:0]  bank_selector_shadow_r;
  reg  [7:0]  rdata_r;
  reg  [7:0]  result_r;
  reg  [7:0]  watchdog_counter_r;
  reg  [7:0]  postscaler_r;
  wire        run;
  wire        is_call;
  wire        is_clr;
  wire        is_com;
  wire        is_clrwdg;
  wire        hi_ok;
  wire [11:0] data_addr;
  wire        bus_wr;
  wire [2:0]  bus_idx;
  wire [31:0] bus_wdata;
  wire [223:0] rd_words;

  assign run       = ctrl_r[`CCWE_CTRL_RUN_BIT];
  assign phase_out = phase_r;

  // The idle second cycle of a call decodes nothing.
  assign is_call   = !idle_cycle_r && (ccwe_class(ir_r) == 2'd1);             // [RULE_01]
  assign is_clr    = !idle_cycle_r && (ccwe_class(ir_r) == 2'd2);             // [RULE_07]
  assign is_com    = !idle_cycle_r && (ccwe_class(ir_r) == 2'd3);             // [RULE_12]
  assign is_clrwdg = !idle_cycle_r && (ir_r == `CCWE_OP_CLRWDG);              // [RULE_10]
  assign hi_ok     = (instr_in[15:12] == `CCWE_OP_CALL_HI);                   // [RULE_01]

  // ----------------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------------
  ccwe_addr_calc u_addr
  (
    .reg_addr_in      (instr_in[7:0]),
    .access_sel_in    (instr_in[8]),
    .bank_selector_in (bank_r),
    .ext_enable_in    (ctrl_r[`CCWE_CTRL_EXT_BIT]),
    .index_base_in    (index_base_in),
    .data_addr_out    (data_addr)
  );

  assign rd_words = {
    {11'h0, top_of_stack_out},
    {8'h00, postscaler_r, 8'h00, watchdog_counter_r},
    {12'h000, bank_selector_shadow_r, 3'h0, status_shadow_r, working_shadow_r},
    {20'h0, bank_r, w_r},
    {11'h0, pc_r},
    {20'h0, 1'b0, time_out_flag_out, power_down_flag_out, 4'h0, status_r},
    {30'h0, ctrl_r}
  };

  ccwe_ahb_regs u_bus
  (
    .clock_in      (clock_in),
    .rst_in        (rst_in),
    .hsel_in       (hsel_in),
    .haddr_in      (haddr_in),
    .htrans_in     (htrans_in),
    .hwrite_in     (hwrite_in),
    .hsize_in      (hsize_in),
    .hready_in     (hready_in),
    .hwdata_in     (hwdata_in),
    .hrdata_out    (hrdata_out),
    .hreadyout_out (hreadyout_out),
    .hresp_out     (hresp_out),
    .rd_words_in   (rd_words),
    .wr_en_out     (bus_wr),
    .wr_idx_out    (bus_idx),
    .wr_data_out   (bus_wdata)
  );

  // ----------------------------------------------------------------------
  // Phase sequencer
  // ----------------------------------------------------------------------
  // Phases stop rotating while the run bit is low, freezing the core.
  always @*
  begin
    case (phase_r)
      PH_Q1:   phase_nxt = PH_Q2;
      PH_Q2:   phase_nxt = PH_Q3;
      PH_Q3:   phase_nxt = PH_Q4;
      PH_Q4:   phase_nxt = PH_Q1;
      default: phase_nxt = PH_Q1;
    endcase
  end

  always @(posedge clock_in)
  begin
    if (rst_in)
      phase_r <= PH_Q1;
    else if (run)
      phase_r <= phase_nxt;
  end

  // Fetch address: the call reads its second word from the next location.
  always @*
  begin
    if (phase_r != PH_Q1 && is_call)
      fetch_addr_out = pc_r + 21'd2;                                          // [RULE_01]
    else
      fetch_addr_out = pc_r;
  end

  // ----------------------------------------------------------------------
  // Instruction flow and program counter
  // ----------------------------------------------------------------------
  // A wrong second-word prefix turns the call into a plain skip past both words.
  always @(posedge clock_in)
  begin
    if (rst_in)
    begin
      pc_r             <= `CCWE_PC_RESET;
      ir_r             <= 16'h0000;
      idle_cycle_r     <= 1'b0;
      stack_push_out   <= 1'b0;
      top_of_stack_out <= 21'h000000;
    end
    else
    begin
      stack_push_out <= 1'b0;
      if (run)
      begin
        case (phase_r)
          PH_Q1:
          begin
            if (!idle_cycle_r)
              ir_r <= instr_in;
          end
          PH_Q3:
          begin
            if (is_call && hi_ok)
            begin
              stack_push_out   <= 1'b1;                                       // [RULE_02]
              top_of_stack_out <= pc_r + 21'd4;                               // [RULE_02]
            end
          end
          PH_Q4:
          begin
            if (idle_cycle_r)
              idle_cycle_r <= 1'b0;                                           // [RULE_06]
            else if (is_call && hi_ok)
            begin
              pc_r         <= {instr_in[11:0], ir_r[7:0], 1'b0};              // [RULE_05]
              idle_cycle_r <= 1'b1;                                           // [RULE_06]
            end
            else if (is_call)
              pc_r <= pc_r + 21'd4;
            else
              pc_r <= pc_r + 21'd2;
          end
          default:
          begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Data memory cycle: read in Q2, process in Q3, write in Q4
  // ----------------------------------------------------------------------
  // Strobes are registered so each stands for exactly one phase.
  always @(posedge clock_in)
  begin
    if (rst_in)
    begin
      dmem_addr_out  <= 12'h000;
      dmem_rd_out    <= 1'b0;
      dmem_wr_out    <= 1'b0;
      dmem_wdata_out <= 8'h00;
      rdata_r        <= 8'h00;
      result_r       <= 8'h00;
    end
    else
    begin
      dmem_rd_out <= 1'b0;
      dmem_wr_out <= 1'b0;
      if (run)
      begin
        case (phase_r)
          PH_Q1:
          begin
            if (ccwe_class(instr_in) >= 2'd2 && !idle_cycle_r)
            begin
              dmem_rd_out <= 1'b1;                                            // [RULE_13]
            end
          end
          PH_Q2:
          begin
            rdata_r <= dmem_rdata_in;                                         // [RULE_13]
          end
          PH_Q3:
          begin
            result_r <= is_clr ? 8'h00 : ~rdata_r;                            // [RULE_07]
            if (is_clr || (is_com && !ir_r[9]))
            begin
              dmem_wr_out    <= 1'b1;                                         // [RULE_13]
              dmem_wdata_out <= is_clr ? 8'h00 : ~rdata_r;                    // [RULE_12]
            end
          end
          default:
          begin
          end
        endcase
      end
      if (phase_r == PH_Q1)
        dmem_addr_out <= data_addr;
    end
  end

  // ----------------------------------------------------------------------
  // Working register, status, bank selector and shadows
  // ----------------------------------------------------------------------
  // The core's own update wins over a bus write in the same cycle.
  always @(posedge clock_in)
  begin
    if (rst_in)
    begin
      w_r                    <= `CCWE_W_RESET;
      status_r               <= `CCWE_STATUS_RESET;
      bank_r                 <= `CCWE_BANK_RESET;
      working_shadow_r       <= `CCWE_W_RESET;
      status_shadow_r        <= `CCWE_STATUS_RESET;
      bank_selector_shadow_r <= `CCWE_BANK_RESET;
    end
    else
    begin
      if (bus_wr && bus_idx == 3'd3)
      begin
        w_r    <= bus_wdata[7:0];
        bank_r <= bus_wdata[11:8];
      end
      if (bus_wr && bus_idx == 3'd1)
        status_r <= bus_wdata[4:0];
      if (run && phase_r == PH_Q3 && is_call && hi_ok && ir_r[8])
      begin
        working_shadow_r       <= w_r;                                        // [RULE_03]
        status_shadow_r        <= status_r;                                   // [RULE_03]
        bank_selector_shadow_r <= bank_r;                                     // [RULE_03]
      end
      if (run && phase_r == PH_Q4 && is_clr)
        status_r[`CCWE_ST_Z] <= 1'b1;                                         // [RULE_07]
      if (run && phase_r == PH_Q4 && is_com)
      begin
        status_r[`CCWE_ST_N] <= result_r[7];                                  // [RULE_12]
        status_r[`CCWE_ST_Z] <= (result_r == 8'h00);                          // [RULE_12]
        if (ir_r[9])
          w_r <= result_r;                                                    // [RULE_12]
      end
    end
  end

  // ----------------------------------------------------------------------
  // Control register and watchdog
  // ----------------------------------------------------------------------
  // The watchdog counter runs off the clock; the postscaler counts its wraps.
  // Only the clear is modelled here; time-out action belongs to the reset logic.
  always @(posedge clock_in)
  begin
    if (rst_in)
    begin
      ctrl_r              <= `CCWE_CTRL_RESET;
      watchdog_counter_r  <= 8'h00;
      postscaler_r        <= 8'h00;
      time_out_flag_out   <= `CCWE_FLAGS_RESET;
      power_down_flag_out <= `CCWE_FLAGS_RESET;
    end
    else
    begin
      if (bus_wr && bus_idx == 3'd0)
        ctrl_r <= bus_wdata[1:0];
      if (bus_wr && bus_idx == 3'd1)
      begin
        time_out_flag_out   <= bus_wdata[10];
        power_down_flag_out <= bus_wdata[9];
      end
      if (run && phase_r == PH_Q3 && is_clrwdg)
      begin
        watchdog_counter_r  <= 8'h00;                                         // [RULE_10]
        postscaler_r        <= 8'h00;                                         // [RULE_11]
        time_out_flag_out   <= 1'b1;                                          // [RULE_10]
        power_down_flag_out <= 1'b1;                                          // [RULE_10]
      end
      else
      begin
        watchdog_counter_r <= watchdog_counter_r + 8'h01;
        if (watchdog_counter_r == 8'hff)
          postscaler_r <= postscaler_r + 8'h01;
      end
    end
  end

  // Shadows are only written in the save branch above, so save bit zero
  // leaves them untouched. [RULE_04]

endmodule // ccwe_exec

/* File: hdl/ccwe_defs.vh */
// Constants for the call, clear and watchdog execute block.
`ifndef CCWE_DEFS_VH
`define CCWE_DEFS_VH

// ----------------------------------------------------------------------
// Register map (byte offsets on the bus)
// ----------------------------------------------------------------------
`define CCWE_OFF_CTRL      8'h00
`define CCWE_OFF_STATUS    8'h04
`define CCWE_OFF_PC        8'h08
`define CCWE_OFF_WBANK     8'h0c
`define CCWE_OFF_SHADOW    8'h10
`define CCWE_OFF_WDOG      8'h14
`define CCWE_OFF_TOS       8'h18
`define CCWE_NUM_REGS      3'd7

// ----------------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------------
`define CCWE_CTRL_EXT_BIT  0
`define CCWE_CTRL_RUN_BIT  1
`define CCWE_CTRL_RESET    2'b10
`define CCWE_PC_RESET      21'h000000
`define CCWE_W_RESET       8'h00
`define CCWE_BANK_RESET    4'h0
`define CCWE_STATUS_RESET  5'h00
`define CCWE_FLAGS_RESET   1'b1

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define CCWE_ST_Z          2
`define CCWE_ST_N          4

// ----------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------
`define CCWE_OP_CALL       7'b1110110
`define CCWE_OP_CALL_HI    4'hf
`define CCWE_OP_CLRREG     7'b0110101
`define CCWE_OP_COMREG     6'b000111
`define CCWE_OP_CLRWDG     16'h0004

// ----------------------------------------------------------------------
// Addressing
// ----------------------------------------------------------------------
`define CCWE_ACCESS_SPLIT  8'h80
`define CCWE_INDEX_LIMIT   8'h5f
`define CCWE_ACCESS_HI     4'hf

`endif

/* File: hdl/ccwe_addr_calc.v */
// Data memory address former for register-operand instructions.
`timescale 1ns/1ps
module ccwe_addr_calc
(
  // Operand fields
  input  wire [7:0]  reg_addr_in,
  input  wire        access_sel_in,
  // Context
  input  wire [3:0]  bank_selector_in,
  input  wire        ext_enable_in,
  input  wire [11:0] index_base_in,
  // Result
  output reg  [11:0] data_addr_out
);
`include "ccwe_defs.vh"

  // Access bit one takes the bank selector; zero takes the access bank or indexed mode.
  always @*
  begin
    if (access_sel_in)
      data_addr_out = {bank_selector_in, reg_addr_in};                // [RULE_08]
    else if (ext_enable_in && (reg_addr_in <= `CCWE_INDEX_LIMIT))
      data_addr_out = index_base_in + {4'h0, reg_addr_in};           // [RULE_09]
    else if (reg_addr_in < `CCWE_ACCESS_SPLIT)
      data_addr_out = {4'h0, reg_addr_in};                           // [RULE_08]
    else
      data_addr_out = {`CCWE_ACCESS_HI, reg_addr_in};                // [RULE_08]
  end

endmodule // ccwe_addr_calc

/* File: hdl/ccwe_ahb_regs.v */
// AHB-Lite slave front end: write strobes out, registered read data back.
`timescale 1ns/1ps
module ccwe_ahb_regs
(
  // Clock and reset
  input  wire         clock_in,
  input  wire         rst_in,
  // AHB-Lite slave
  input  wire         hsel_in,
  input  wire [31:0]  haddr_in,
  input  wire [1:0]   htrans_in,
  input  wire         hwrite_in,
  input  wire [2:0]   hsize_in,
  input  wire         hready_in,
  input  wire [31:0]  hwdata_in,
  output reg  [31:0]  hrdata_out,
  output wire         hreadyout_out,
  output wire         hresp_out,
  // Register side
  input  wire [223:0] rd_words_in,
  output wire         wr_en_out,
  output wire [2:0]   wr_idx_out,
  output wire [31:0]  wr_data_out
);
`include "ccwe_defs.vh"

  reg        wr_pend_r;
  reg  [2:0] wr_idx_r;
  wire       addr_ok;
  wire [2:0] idx;
  wire       take;

  // Only whole aligned words inside the map are decoded; the rest reads zero.
  assign idx     = haddr_in[4:2];
  assign addr_ok = (haddr_in[31:5] == 27'h0) && (haddr_in[1:0] == 2'b00) &&
                   (hsize_in == 3'b010) && (haddr_in[7:2] < {3'b000, `CCWE_NUM_REGS});
  assign take    = hsel_in && htrans_in[1] && hready_in;

  // Never waits and never errors, so the data phase is always one cycle.
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
  assign wr_en_out     = wr_pend_r;
  assign wr_idx_out    = wr_idx_r;
  assign wr_data_out   = hwdata_in;

  // Address phase capture: write target held for the data phase, read data fetched now.
  always @(posedge clock_in)
  begin
    if (rst_in)
    begin
      wr_pend_r  <= 1'b0;
      wr_idx_r   <= 3'h0;
      hrdata_out <= 32'h00000000;
    end
    else
    begin
      wr_pend_r <= take && hwrite_in && addr_ok;
      wr_idx_r  <= idx;
      if (take && !hwrite_in)
        hrdata_out <= addr_ok ? rd_words_in[idx*32 +: 32] : 32'h00000000;
    end
  end

endmodule // ccwe_ahb_regs

/* File: bench/ccwe_mem_model.sv */
// Program memory and data memory model for the execute unit's far side.
`timescale 1ns/1ps
module ccwe_mem_model
(
  // Clock
  input  wire logic        clock_in,
  // Program fetch
  input  wire logic [20:0] fetch_addr_in,
  output      logic [15:0] instr_out,
  // Data memory
  input  wire logic [11:0] dmem_addr_in,
  input  wire logic        dmem_rd_in,
  output      logic [7:0]  dmem_rdata_out,
  input  wire logic        dmem_wr_in,
  input  wire logic [7:0]  dmem_wdata_in
);
  logic [15:0] prog [0:255];
  logic [7:0]  dmem [0:4095];
  logic [7:0]  last_r = 8'h00;

  // Program words are fetched by byte address, so bit 0 is ignored.
  assign instr_out = prog[fetch_addr_in[8:1]];
  // Outside a read strobe the bus shows the inverse of the last read, never stale data.
  assign dmem_rdata_out = dmem_rd_in ? dmem[dmem_addr_in] : ~last_r;

  // Writes land on the edge that ends the write strobe.
  always @(posedge clock_in)
  begin
    if (dmem_rd_in)
      last_r <= dmem[dmem_addr_in];
    if (dmem_wr_in)
      dmem[dmem_addr_in] <= dmem_wdata_in;
  end
endmodule // ccwe_mem_model

/* File: bench/ccwe_exec_chk.sv */
// Concurrent checks on the execute unit's ports.
`timescale 1ns/1ps
module ccwe_exec_chk
(
  // Clock and reset
  input wire logic        clock_in,
  input wire logic        rst_in,
  // Observed ports
  input wire logic [20:0] fetch_addr_out,
  input wire logic [15:0] instr_in,
  input wire logic [11:0] dmem_addr_out,
  input wire logic        dmem_rd_out,
  input wire logic [7:0]  dmem_rdata_in,
  input wire logic        dmem_wr_out,
  input wire logic [7:0]  dmem_wdata_out,
  input wire logic        stack_push_out,
  input wire logic [20:0] top_of_stack_out,
  input wire logic        time_out_flag_out,
  input wire logic        power_down_flag_out,
  input wire logic [3:0]  phase_out
);
  logic [15:0] w1_r;
  logic        idle_r;
  logic        q2;
  logic        q4;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  assign q2 = (phase_out == 4'b0010) && !idle_r;
  assign q4 = (phase_out == 4'b1000) && !idle_r;

  // Shadow decoder: the word taken at the end of Q1, skipped in the idle cycle of a call.
  always @(posedge clock_in)
  begin
    if (rst_in)
    begin
      w1_r   <= 16'h0000;
      idle_r <= 1'b0;
    end
    else
    begin
      if (phase_out == 4'b0001 && !idle_r)
        w1_r <= instr_in;
      if (stack_push_out)
        idle_r <= 1'b1;
      else if (phase_out == 4'b1000)
        idle_r <= 1'b0;
    end
  end

  a_phase_rotate: assert property (phase_out == 4'b0001 |=> phase_out == 4'b0010 ##1
    phase_out == 4'b0100 ##1 phase_out == 4'b1000 ##1 phase_out == 4'b0001)
    else $error("phase sequence broken");
  a_push_call_q4: assert property (stack_push_out |-> phase_out == 4'b1000 &&
    w1_r[15:9] == 7'b1110110) else $error("push outside call Q4");
  a_push_ret_addr: assert property (stack_push_out |->
    top_of_stack_out == fetch_addr_out + 21'd2) else $error("return address wrong");
  a_call_pc_load: assert property (stack_push_out |=>
    fetch_addr_out == {$past(instr_in[11:0]), w1_r[7:0], 1'b0}) else $error("call target wrong");
  a_call_idle_cyc: assert property (stack_push_out |=>
    (!stack_push_out && !dmem_rd_out && !dmem_wr_out)[*4]) else $error("second call cycle busy");
  a_clear_reads: assert property (q2 && w1_r[15:9] == 7'b0110101 |-> dmem_rd_out)
    else $error("clear missed read");
  a_clear_zero: assert property (q4 && w1_r[15:9] == 7'b0110101 |->
    dmem_wr_out && dmem_wdata_out == 8'h00) else $error("clear wrote nonzero");
  a_comp_invert: assert property (q4 && w1_r[15:9] == 7'b0001110 |->
    dmem_wr_out && dmem_wdata_out == ~$past(dmem_rdata_in, 2)) else $error("complement wrong");
  a_wdog_flags: assert property (q4 && w1_r == 16'h0004 |->
    time_out_flag_out && power_down_flag_out) else $error("watchdog flags not set");
  a_access_addr: assert property (q2 && w1_r[15:8] == 8'h6a && w1_r[7:0] > 8'h5f |->
    dmem_addr_out == {{4{w1_r[7]}}, w1_r[7:0]}) else $error("access bank address wrong");

  c_call: cover property (stack_push_out);
  c_clear: cover property (q4 && w1_r[15:9] == 7'b0110101 && dmem_wr_out);
  c_comp: cover property (q4 && w1_r[15:9] == 7'b0001110 && dmem_wr_out);
endmodule // ccwe_exec_chk

/* File: bench/testbench.sv */
// Self-checking testbench for the call, clear and watchdog execute unit.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module testbench;
  logic        clock_in;
  logic        rst_in;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [11:0] index_base;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;
  wire  [20:0] fetch_addr;
  wire  [15:0] instr;
  wire  [11:0] dmem_addr;
  wire         dmem_rd;
  wire  [7:0]  dmem_rdata;
  wire         dmem_wr;
  wire  [7:0]  dmem_wdata;
  wire         to_flag;
  wire         pd_flag;
  int          miscompares;
  int          n_tests;

  ccwe_exec dut (.clock_in(clock_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'b010), .hready_in(hreadyout),
    .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hreadyout), .hresp_out(hresp),
    .fetch_addr_out(fetch_addr), .instr_in(instr), .index_base_in(index_base),
    .dmem_addr_out(dmem_addr), .dmem_rd_out(dmem_rd), .dmem_rdata_in(dmem_rdata),
    .dmem_wr_out(dmem_wr), .dmem_wdata_out(dmem_wdata), .stack_push_out(),
    .top_of_stack_out(), .time_out_flag_out(to_flag), .power_down_flag_out(pd_flag),
    .phase_out());

  ccwe_mem_model mem (.clock_in(clock_in), .fetch_addr_in(fetch_addr), .instr_out(instr),
    .dmem_addr_in(dmem_addr), .dmem_rd_in(dmem_rd), .dmem_rdata_out(dmem_rdata),
    .dmem_wr_in(dmem_wr), .dmem_wdata_in(dmem_wdata));

  // Free-running 100 MHz clock.
  initial
  begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  // The slave never stretches; a wait that never ends would still be cut and counted.
  task automatic wait_ready();
    int n;
    begin
      n = 0;
      while (hreadyout !== 1'b1 && n < 64)
      begin
        @(posedge clock_in);
        n++;
      end
      if (n >= 64)
        miscompares++;
    end
  endtask

  // One single word transfer: address phase, then data phase.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    begin
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= wr;
      htrans <= 2'b10;
      @(posedge clock_in);
      wait_ready();
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge clock_in);
      wait_ready();
      r = hrdata;
    end
  endtask

  task automatic do_reset();
    begin
      rst_in <= 1'b1;
      repeat (8) @(posedge clock_in);
      rst_in <= 1'b0;
    end
  endtask

  // Fill with no-ops and park the core in a self call at byte address 1e0h.
  task automatic load_base();
    begin
      for (int i = 0; i < 256; i++)
        mem.prog[i] = 16'h0000;
      mem.prog[8'hf0] = 16'hecf0;
      mem.prog[8'hf1] = 16'hf000;
    end
  endtask

  // Long no-op run first so the watchdog counter has wrapped and the postscaler is nonzero before the clear.
  task automatic test_call_clear();
    logic [31:0] r;
    begin
      bus(1'b0, 32'h00, 32'h0, r);
      `CHK("ctrl_reset", 32'h0000_0002, r)
      bus(1'b0, 32'h04, 32'h0, r);
      `CHK("status_reset", 32'h0000_0600, r)
      bus(1'b0, 32'h1c, 32'h0, r);
      `CHK("unmapped", 32'h0, r)
      `CHK("hresp", 1'b0, hresp)
      bus(1'b1, 32'h04, 32'h0, r);
      bus(1'b1, 32'h0c, 32'h0000_05a3, r);
      repeat (720) @(posedge clock_in);
      `CHK("clr_access", 8'h00, mem.dmem[12'h020])
      `CHK("clr_banked", 8'h00, mem.dmem[12'h585])
      `CHK("com_file", 8'hf0, mem.dmem[12'h030])
      `CHK("to_flag", 1'b1, to_flag)
      `CHK("pd_flag", 1'b1, pd_flag)
      bus(1'b0, 32'h14, 32'h0, r);
      `CHK("postscaler", 8'h00, r[23:16])
      bus(1'b0, 32'h04, 32'h0, r);
      `CHK("status", 32'h0000_0600, r)
      bus(1'b0, 32'h08, 32'h0, r);
      `CHK("pc", 32'h0000_01e0, r)
      bus(1'b0, 32'h18, 32'h0, r);
      `CHK("tos", 32'h0000_01e4, r)
      bus(1'b0, 32'h10, 32'h0, r);
      `CHK("shadow", 32'h0005_10a3, r)
      bus(1'b0, 32'h0c, 32'h0, r);
      `CHK("w_bank", 32'h0000_050f, r)
      $display("test call_clear done");
    end
  endtask

  // Indexed offsets below and at 5Fh, access bank above it.
  task automatic test_indexed();
    logic [31:0] r;
    logic [11:0] pre [6];
    begin
      pre = '{12'h310, 12'h35f, 12'h060, 12'hf90, 12'h010, 12'h05f};
      load_base();
      mem.prog[8]  = 16'h6a10;
      mem.prog[9]  = 16'h6a5f;
      mem.prog[10] = 16'h6a60;
      mem.prog[11] = 16'h6a90;
      foreach (pre[i])
        mem.dmem[pre[i]] = 8'hff;
      do_reset();
      index_base <= 12'h300;
      bus(1'b1, 32'h00, 32'h0000_0003, r);
      repeat (100) @(posedge clock_in);
      `CHK("idx_low", 8'h00, mem.dmem[12'h310])
      `CHK("idx_edge", 8'h00, mem.dmem[12'h35f])
      `CHK("idx_skip_lo", 8'hff, mem.dmem[12'h010])
      `CHK("idx_skip_ed", 8'hff, mem.dmem[12'h05f])
      `CHK("acc_low", 8'h00, mem.dmem[12'h060])
      `CHK("acc_high", 8'h00, mem.dmem[12'hf90])
      $display("test indexed done");
    end
  endtask

  task automatic stop_test();
    begin
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  // Whole run is under a thousand cycles; twice that means a hang.
  initial
  begin
    #20000;
    miscompares++;
    $display("watchdog expired");
    stop_test();
  end

  // Main sequence: program one is loaded before reset lets the core run.
  initial
  begin
    miscompares = 0;
    n_tests     = 0;
    rst_in      = 1'b1;
    hsel        = 1'b0;
    haddr       = 32'h0;
    htrans      = 2'b00;
    hwrite      = 1'b0;
    hwdata      = 32'h0;
    index_base  = 12'h000;
    load_base();
    mem.prog[8'ha0] = 16'h6a20;
    mem.prog[8'ha1] = 16'h6b85;
    mem.prog[8'ha2] = 16'h1c30;
    mem.prog[8'ha3] = 16'h0004;
    mem.prog[8'ha4] = 16'hedc0;
    mem.prog[8'ha5] = 16'hf123;
    mem.prog[8'hc0] = 16'h1e30;
    mem.prog[8'hc1] = 16'hecf0;
    mem.prog[8'hc2] = 16'hf000;
    mem.dmem[12'h020] = 8'h5a;
    mem.dmem[12'h585] = 8'h5a;
    mem.dmem[12'h030] = 8'h0f;
    do_reset();
    test_call_clear();
    test_indexed();
    stop_test();
  end
endmodule // testbench

bind ccwe_exec ccwe_exec_chk u_chk (.clock_in(clock_in), .rst_in(rst_in),
  .fetch_addr_out(fetch_addr_out), .instr_in(instr_in), .dmem_addr_out(dmem_addr_out),
  .dmem_rd_out(dmem_rd_out), .dmem_rdata_in(dmem_rdata_in), .dmem_wr_out(dmem_wr_out),
  .dmem_wdata_out(dmem_wdata_out), .stack_push_out(stack_push_out),
  .top_of_stack_out(top_of_stack_out), .time_out_flag_out(time_out_flag_out),
  .power_down_flag_out(power_down_flag_out), .phase_out(phase_out));
